/* design/low_cap_indicator_sort.sv */
// Low-capacitance reject, handler outputs, sort counters and beep select.
// Assumes one result pulse per measurement from the measuring engine,
// and a register master on the same clock that never waits.
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module low_cap_indicator_sort
	import low_cap_indicator_sort_pkg::*;
#(
	parameter int NUM_CH = 4
) (
	input  wire logic              mclk_i,
	input  wire logic              rst_n_i,
	input  wire logic              ce_i,
	input  wire logic              meas_valid_i,
	input  wire meas_t             meas_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [DATA_W-1:0] rdata_o,
	output handler_t               handler_o,
	output disp_t                  display_o,
	output logic                   beep_o
);

	// Channel count must fit the channel field and the map
	// (the channel field is CH_W bits wide; the map has room for sixty)
	initial begin
		if (NUM_CH < 1 || NUM_CH > (1 << CH_W)) begin
			$error("NUM_CH out of range");
		end
	end

	// Counter slots must fit the 16-word channel stride and a data word
	initial begin
		if (NCLS > 16 || CNT_W > DATA_W) begin
			$error("counter layout does not fit the register map");
		end
	end

	localparam int TOT_WORD  = int'(REG_TOTAL >> 2);
	localparam int CHAN_WORD = int'(REG_CHAN >> 2);

	// Settings
	logic [6:0]  ctrl;                     // Control fields
	logic [16:0] pct;                      // Boundary in 0.001 % units
	logic [15:0] result;                   // Last result for readout

	// Decoded control fields
	logic  cmp_en;
	logic  low_cap_indicator_en;
	logic  cnt_en;
	logic  multi_en;
	logic  auto_rng;
	beep_t beep_mode;

	// Strobes for this cycle
	// Each is qualified by the clock enable once, here, so no
	// process further down can act on a frozen cycle by mistake
	logic take;                            // Measurement accepted
	logic wr_ctrl;
	logic wr_pct;
	logic wr_cmd;
	logic clr_cnt;

	// Low capacitance comparison
	// A part without contact is never called low capacitance here;
	// the shared handler line still shows it through its own term
	logic [2:0]  rng_eff;                  // Range that sets full scale
	logic [63:0] fs_af;                    // Full scale in aF
	logic [67:0] lhs;                      // Value times 100 %
	logic [67:0] rhs;                      // Percentage times full scale
	logic        below;                    // At or below boundary
	logic        low_cap_indicator_hit;                 // Detected and enabled

	// Sort qualifiers
	logic       sorted;                    // Sort ran for this part
	logic [3:0] cnt_idx;                   // Counter slot hit
	logic       cnt_hit;                   // Some counter advances
	logic       fail_kind;                 // Beep class for fail
	logic       pass_kind;                 // Beep class for pass

	// Counter values
	// Totals hold one slot per class plus the overrange slot
	logic [CNT_W-1:0] tot_cnt  [NCLS];
	logic [CNT_W-1:0] chan_cnt [NUM_CH*NCLS];

	// Register reads
	// Word index drops the two byte-address bits
	logic [ADDR_W-3:0] word;
	logic [DATA_W-1:0] next_rdata;

	// Full scale of a range code in aF
	// One multiply by ten per step of the range code; the loop is
	// unrolled, so this is a short chain of constant multipliers
	function automatic logic [63:0] full_scale(input logic [2:0] code);
		logic [63:0] fs;
		fs = FS_BASE_AF;
		for (int i = 0; i < 7; i++) begin
			if (i < int'(code)) begin
				fs = 64'(fs * 64'h000000000000000A);
			end
		end
		return fs;
	endfunction

	assign cmp_en    = ctrl[CTRL_CMP_EN];
	assign low_cap_indicator_en   = ctrl[CTRL_LOW_CAP_INDICATOR_EN];
	assign cnt_en    = ctrl[CTRL_CNT_EN];
	assign multi_en  = ctrl[CTRL_MULTI];
	assign auto_rng  = ctrl[CTRL_AUTO];
	assign beep_mode = beep_t'(ctrl[CTRL_BEEP +: 2]);

	assign take    = ce_i && meas_valid_i;
	assign wr_ctrl = ce_i && wr_i && addr_i == REG_CTRL;
	assign wr_pct  = ce_i && wr_i && addr_i == REG_PCT;
	assign wr_cmd  = ce_i && wr_i && addr_i == REG_CMD;
	assign clr_cnt = wr_cmd && wdata_i[CMD_CLR];
	assign word    = addr_i[ADDR_W-1:2];

	// Pick the range whose full scale sets the boundary
	// In auto range the range actually used is ignored on purpose: the
	// boundary stays put while the engine hunts between ranges
	always_comb begin
		if (auto_rng) begin
			// Smallest range for the test frequency
			case (meas_i.freq)
				FREQ_120HZ: rng_eff = RANGE_MIN_120HZ;
				FREQ_1KHZ:  rng_eff = RANGE_MIN_1KHZ;
				default:    rng_eff = RANGE_MIN_1MHZ;
			endcase
		end else begin
			// Range the measurement ran in
			rng_eff = meas_i.range_code;
		end
	end

	// Boundary compare without division: value*100% <= pct*FS
	// Cross-multiplied so that no divider sits in the path; both
	// products stay inside 68 bits for every legal range code
	always_comb begin
		fs_af    = full_scale(rng_eff);
		lhs      = 68'(meas_i.parallel_capacitance) * 68'(PCT_FULL);
		rhs      = 68'(pct) * 68'(fs_af);
		below    = lhs <= rhs;
		low_cap_indicator_hit = low_cap_indicator_en && below && !meas_i.overload && !meas_i.no_contact;
	end

	// Sort outcome, counter slot and beep class
	// An overrange part has no meaningful class, so it is steered
	// to its own counter slot and kept out of the class counters
	always_comb begin
		sorted    = !meas_i.overload && !meas_i.no_contact;
		cnt_idx   = meas_i.overload ? CNT_OVERRANGE_FLAG : meas_i.cls;
		cnt_hit   = meas_i.overload || (sorted && meas_i.cls <= CLS_AUX);
		fail_kind = meas_i.overload || meas_i.no_contact || low_cap_indicator_hit
			|| meas_i.cls == CLS_REJECT || meas_i.cls == CLS_AUX;
		pass_kind = sorted && !low_cap_indicator_hit && meas_i.cls != CLS_REJECT
			&& meas_i.cls < CLS_AUX;
	end

	// Control register
	// All fields are written at once; beep code 3 behaves as off
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl <= CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl <= wdata_i[6:0];
		end
	end

	// Boundary percentage: direct entry or single steps, clamped
	// Up and down in one command cancel, so a confused command
	// leaves the boundary where it was instead of picking a side
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pct <= PCT_RST;
		end else if (wr_pct) begin
			// Direct entry, capped at full scale
			pct <= (wdata_i[16:0] > PCT_FULL) ? PCT_FULL : wdata_i[16:0];
		end else if (wr_cmd && wdata_i[CMD_UP] && !wdata_i[CMD_DN]) begin
			// Step up one increment
			if (pct <= PCT_FULL - PCT_STEP) begin
				pct <= pct + PCT_STEP;
			end
		end else if (wr_cmd && wdata_i[CMD_DN] && !wdata_i[CMD_UP]) begin
			// Step down one increment
			if (pct >= PCT_STEP) begin
				pct <= pct - PCT_STEP;
			end
		end
	end

	// Handler lines, updated together per measurement
	// Every line is rewritten on each result so no stale class from an
	// earlier part survives; the shared low-cap line switches on the
	// same edge as the class lines, so the handler sees one picture
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			handler_o <= HDL_IDLE;
		end else if (ce_i) begin
			if (!cmp_en) begin
				// Sort lines idle, done held low, alarm still live
				handler_o.sort_class_n        <= '1;
				handler_o.reject_all_result_n <= 1'b1;
				handler_o.aux_n               <= 1'b1;
				handler_o.overrange_flag_n    <= 1'b1;
				handler_o.low_cap_or_open_n   <= 1'b1;
				handler_o.measure_done_n      <= 1'b0;
				if (take) begin
					handler_o.alarm_n <= !meas_i.error;
				end
			end else if (take) begin
				// New result; all lines switch in the same cycle
				handler_o.sort_class_n        <= '1;
				handler_o.reject_all_result_n <= 1'b1;
				handler_o.aux_n               <= 1'b1;
				handler_o.measure_done_n      <= 1'b0;
				handler_o.alarm_n             <= !meas_i.error;
				handler_o.overrange_flag_n    <= !meas_i.overload;
				handler_o.low_cap_or_open_n   <= !(meas_i.no_contact || low_cap_indicator_hit);
				if (sorted) begin
					// Normal sort still drives its line
					if (meas_i.cls == CLS_REJECT) begin
						handler_o.reject_all_result_n <= 1'b0;
					end else if (meas_i.cls == CLS_AUX) begin
						handler_o.aux_n <= 1'b0;
					end else if (meas_i.cls < CLS_AUX) begin
						handler_o.sort_class_n[meas_i.cls - 4'h1] <= 1'b0;
					end
				end
			end else begin
				// Done is a one-cycle low strobe
				handler_o.measure_done_n <= 1'b1;
			end
		end
	end

	// Upper display line selection
	// Overrange outranks low capacitance, since no value was taken
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			display_o <= DISP_CLASS;
		end else if (take) begin
			if (meas_i.overload) begin
				display_o <= DISP_DASH;
			end else if (low_cap_indicator_hit || meas_i.no_contact) begin
				display_o <= DISP_LOW_CAP_INDICATOR;
			end else begin
				display_o <= DISP_CLASS;
			end
		end
	end

	// Result word: status, low-cap flag, class code
	// Held while the comparator is off so that software keeps seeing
	// the last real sort rather than a part that was never sorted
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			result <= '0;
		end else if (take && cmp_en) begin
			result[3:0] <= sorted ? meas_i.cls : CLS_NONE;
			result[4]   <= low_cap_indicator_hit;
			if (meas_i.overload) begin
				result[9:8] <= STAT_OVERRANGE_FLAG;
			end else if (low_cap_indicator_hit || meas_i.no_contact) begin
				result[9:8] <= STAT_LOW_CAP_INDICATOR;
			end else begin
				result[9:8] <= STAT_OK;
			end
			result[15:10] <= 6'(meas_i.chan);
		end
	end

	// Beep pulse by selected condition
	// One cycle per result; nothing is stretched here
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			beep_o <= 1'b0;
		end else if (ce_i) begin
			case (beep_mode)
				BEEP_FAIL: beep_o <= take && cmp_en && fail_kind;
				BEEP_PASS: beep_o <= take && cmp_en && pass_kind;
				default:   beep_o <= 1'b0;
			endcase
		end
	end

	// All-channel totals, one slot per class plus overrange
	// One shared clear line, so every count drops to zero together
	for (genvar g = 0; g < NCLS; g++) begin : g_tot
		sat_counter u_tot (
			.mclk_i  (mclk_i),
			.rst_n_i (rst_n_i),
			.ce_i    (ce_i),
			.clr_i   (clr_cnt),
			.inc_i   (take && cmp_en && cnt_en && cnt_hit && cnt_idx == 4'(g)),
			.count_o (tot_cnt[g])
		);
	end

	// Per-channel counts, only while multi-channel mode is on
	// A channel number at or above NUM_CH matches no counter and is lost;
	// totals still count such a part
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		for (genvar g = 0; g < NCLS; g++) begin : g_cls
			sat_counter u_ch (
				.mclk_i  (mclk_i),
				.rst_n_i (rst_n_i),
				.ce_i    (ce_i),
				.clr_i   (clr_cnt),
				.inc_i   (take && cmp_en && cnt_en && multi_en && cnt_hit
					&& cnt_idx == 4'(g) && meas_i.chan == CH_W'(c)),
				.count_o (chan_cnt[c*NCLS+g])
			);
		end
	end

	// Read decode; unmapped words read zero
	// Totals and each channel block share one layout, class k at word k;
	// the spare words at the end of a 16-word channel block read zero
	always_comb begin
		next_rdata = '0;
		if (addr_i == REG_CTRL) begin
			next_rdata = DATA_W'(ctrl);
		end else if (addr_i == REG_PCT) begin
			next_rdata = DATA_W'(pct);
		end else if (addr_i == REG_RESULT) begin
			next_rdata = DATA_W'(result);
		end else if (int'(word) >= TOT_WORD && int'(word) < TOT_WORD + NCLS) begin
			next_rdata = DATA_W'(tot_cnt[int'(word) - TOT_WORD]);
		end else if (int'(word) >= CHAN_WORD && int'(word) < CHAN_WORD + 16 * NUM_CH
			&& (int'(word) - CHAN_WORD) % 16 < NCLS) begin
			next_rdata = DATA_W'(chan_cnt[((int'(word) - CHAN_WORD) / 16) * NCLS
				+ (int'(word) - CHAN_WORD) % 16]);
		end
	end

	// Read data stands the cycle after the strobe only
	// Forcing zero outside a read keeps old counts off the shared bus
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= '0;
		end else if (ce_i) begin
			rdata_o <= rd_i ? next_rdata : '0;
		end
	end

endmodule

/* design/low_cap_indicator_sort_pkg.sv */
// Constants, types and register map for the low-capacitance reject and sort counting block.
// Assumes one 200 MHz clock and a plain register port driven by local software.
package low_cap_indicator_sort_pkg;

	// Bus and counter widths
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int CNT_W  = 20;
	localparam int CH_W   = 3;
	localparam int NCLS   = 12;              // Classes 0..10 plus overrange slot

	// Counter ceiling, 999999
	localparam logic [CNT_W-1:0] CNT_MAX = 20'hF423F;

	// Boundary percentage in units of 0.001 %
	localparam logic [16:0] PCT_FULL = 17'h186A0;   // 100 %
	localparam logic [16:0] PCT_STEP = 17'h00001;   // 0.001 %
	localparam logic [16:0] PCT_RST  = 17'h00000;

	// Range codes: full scale is 1 pF times ten to the code, in aF
	localparam logic [63:0] FS_BASE_AF = 64'h00000000000F4240;
	localparam logic [2:0]  RANGE_MIN_120HZ = 3'h4;  // 10 nF
	localparam logic [2:0]  RANGE_MIN_1KHZ  = 3'h2;  // 100 pF
	localparam logic [2:0]  RANGE_MIN_1MHZ  = 3'h0;  // 1 pF

	// Register byte offsets
	localparam logic [ADDR_W-1:0] REG_CTRL   = 12'h000;
	localparam logic [ADDR_W-1:0] REG_PCT    = 12'h004;
	localparam logic [ADDR_W-1:0] REG_CMD    = 12'h008;
	localparam logic [ADDR_W-1:0] REG_RESULT = 12'h00C;
	localparam logic [ADDR_W-1:0] REG_TOTAL  = 12'h040;  // NCLS words
	localparam logic [ADDR_W-1:0] REG_CHAN   = 12'h100;  // 16 words per channel

	// Control register fields
	localparam int CTRL_CMP_EN  = 0;
	localparam int CTRL_LOW_CAP_INDICATOR_EN = 1;
	localparam int CTRL_CNT_EN  = 2;
	localparam int CTRL_MULTI   = 3;
	localparam int CTRL_AUTO    = 4;
	localparam int CTRL_BEEP    = 5;    // Two bits
	localparam logic [6:0] CTRL_RST = 7'h40;

	// Command register fields
	localparam int CMD_UP  = 0;
	localparam int CMD_DN  = 1;
	localparam int CMD_CLR = 2;

	// Class codes and result status codes
	localparam logic [3:0] CLS_REJECT = 4'h0;
	localparam logic [3:0] CLS_AUX    = 4'hA;
	localparam logic [3:0] CLS_NONE   = 4'hB;   // Cannot be sorted
	localparam logic [3:0] CNT_OVERRANGE_FLAG   = 4'hB;   // Counter slot for overrange
	localparam logic [1:0] STAT_OK    = 2'h0;
	localparam logic [1:0] STAT_OVERRANGE_FLAG  = 2'h1;
	localparam logic [1:0] STAT_LOW_CAP_INDICATOR  = 2'h2;

	typedef enum logic [1:0] {FREQ_120HZ = 2'h0, FREQ_1KHZ = 2'h1, FREQ_1MHZ = 2'h2} freq_t;
	typedef enum logic [1:0] {BEEP_FAIL = 2'h0, BEEP_PASS = 2'h1, BEEP_OFF = 2'h2} beep_t;
	typedef enum logic [2:0] {DISP_CLASS = 3'h1, DISP_DASH = 3'h2, DISP_LOW_CAP_INDICATOR = 3'h4} disp_t;

	// One finished measurement from the measuring engine
	typedef struct packed {
		logic [47:0] parallel_capacitance;  // aF, unsigned
		logic [2:0]  range_code;
		freq_t       freq;
		logic [3:0]  cls;                   // Normal sort class 0..10
		logic        overload;
		logic        no_contact;
		logic        error;
		logic [CH_W-1:0] chan;
	} meas_t;

	// Handler output lines, all active low
	typedef struct packed {
		logic [8:0] sort_class_n;           // Classes 1..9
		logic       reject_all_result_n;
		logic       aux_n;
		logic       overrange_flag_n;
		logic       low_cap_or_open_n;
		logic       measure_done_n;
		logic       alarm_n;
	} handler_t;

	localparam handler_t HDL_IDLE = 15'h7FFF;

endpackage

/* design/sat_counter.sv */
// Saturating event counter with synchronous clear.
// Assumes the caller qualifies inc_i and clr_i with its own enables.
`timescale 1ns/100ps
module sat_counter
	import low_cap_indicator_sort_pkg::*;
#(
	parameter int               WIDTH = CNT_W,
	parameter logic [WIDTH-1:0] MAX   = CNT_MAX
) (
	input  wire logic             mclk_i,
	input  wire logic             rst_n_i,
	input  wire logic             ce_i,
	input  wire logic             clr_i,
	input  wire logic             inc_i,
	output logic      [WIDTH-1:0] count_o
);

	// A counter narrower than one bit cannot count
	initial begin
		if (WIDTH < 1) begin
			$error("WIDTH out of range");
		end
	end

	// Clear first, then count up to the ceiling and stay there
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_o <= '0;
		end else if (ce_i) begin
			if (clr_i) begin
				count_o <= '0;
			end else if (inc_i && count_o != MAX) begin
				count_o <= count_o + 1'b1;
			end
		end
	end

endmodule

/* bench/low_cap_indicator_sort_chk.sv */
// Port checker for the low-capacitance reject and sort block.
// Assumes binding to every low_cap_indicator_sort instance, one clock domain.
`timescale 1ns/100ps
module low_cap_indicator_sort_chk
	import low_cap_indicator_sort_pkg::*;
(
	input  wire logic              mclk_i,
	input  wire logic              rst_n_i,
	input  wire logic              ce_i,
	input  wire logic              meas_valid_i,
	input  wire meas_t             meas_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	input  wire logic [DATA_W-1:0] rdata_o,
	input  wire handler_t          handler_o,
	input  wire disp_t             display_o,
	input  wire logic              beep_o
);
	logic cmp_on;  // Shadow of the comparator enable bit

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	// Follow control writes so the checker knows the comparator state
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cmp_on <= CTRL_RST[CTRL_CMP_EN];
		end else if (ce_i && wr_i && addr_i == REG_CTRL) begin
			cmp_on <= wdata_i[CTRL_CMP_EN];
		end
	end

	// A measurement accepted at this edge
	sequence take_s;
		ce_i && meas_valid_i;
	endsequence
	// A plain part of class 1..9 with the comparator on
	sequence sorted_s;
		take_s ##0 cmp_on && !meas_i.overload && !meas_i.no_contact && !meas_i.error && meas_i.cls inside {[4'h1:4'h9]};
	endsequence

	rdata_idle_a: assert property (ce_i && !rd_i |=> rdata_o == '0)
		else $error("read data not zero outside a read");
	done_pulse_a: assert property (take_s ##0 cmp_on |=> !handler_o.measure_done_n)
		else $error("done strobe missing after measurement");
	off_quiet_a: assert property (take_s ##0 !cmp_on |=> !handler_o.measure_done_n && !beep_o)
		else $error("comparator off output wrong");
	alarm_follow_a: assert property (take_s |=> handler_o.alarm_n == !$past(meas_i.error))
		else $error("alarm line does not follow error");
	ovl_skip_a: assert property (take_s ##0 cmp_on && meas_i.overload |=>
		!handler_o.overrange_flag_n && &handler_o.sort_class_n && display_o == DISP_DASH)
		else $error("overrange result wrong");
	class_line_a: assert property (sorted_s |=>
		handler_o.sort_class_n == ~(9'h001 << ($past(meas_i.cls) - 4'h1)))
		else $error("class line wrong");
	beep_cause_a: assert property (beep_o && $past(ce_i) |-> $past(meas_valid_i))
		else $error("beep without measurement");
	disp_hold_a: assert property (!$past(meas_valid_i) |-> $stable(display_o))
		else $error("display changed between measurements");
endmodule

bind low_cap_indicator_sort low_cap_indicator_sort_chk chk_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .meas_valid_i(meas_valid_i),
	.meas_i(meas_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.handler_o(handler_o), .display_o(display_o), .beep_o(beep_o));

/* bench/handler_model.sv */
// Handler machine model: bins each part on the done strobe.
// Assumes active-low handler lines sampled at the rising edge.
`timescale 1ns/100ps
module handler_model
	import low_cap_indicator_sort_pkg::*;
(
	input  wire logic     mclk_i,
	input  wire logic     rst_n_i,
	input  wire handler_t handler_i,
	output logic [3:0]    bin_o,    // Last class picked, 0 for none
	output logic [15:0]   parts_o   // Done strobes seen
);
	// Pick the low class line whenever done is low
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bin_o   <= 4'h0;
			parts_o <= 16'h0000;
		end else if (!handler_i.measure_done_n) begin
			parts_o <= parts_o + 16'h0001;
			bin_o   <= 4'h0;
			for (int k = 0; k < 9; k++) begin
				if (!handler_i.sort_class_n[k]) begin
					bin_o <= 4'(k + 1);
				end
			end
		end
	end
endmodule

/* bench/tb_top.sv */
// Self-checking bench for low_cap_indicator_sort with a handler model.
// Assumes a 200 MHz clock and a master that never waits.
`timescale 1ns/100ps
module tb_top
	import low_cap_indicator_sort_pkg::*;
;
	logic              mclk_i, rst_n_i, ce_i, meas_valid_i, wr_i, rd_i, beep_o;
	meas_t             meas_i;        // Measurement to the block
	logic [ADDR_W-1:0] addr_i;
	logic [DATA_W-1:0] wdata_i, rdata_o;
	handler_t          handler_o;
	disp_t             display_o;
	logic [3:0]        bin;           // Model's binned class
	logic [15:0]       parts;         // Model's done count
	int                seed = 48;     // Fixed seed
	int                n_errors = 0, total_checks = 0;
	logic [6:0]        ctrl;          // Expected control
	logic [16:0]       pct;           // Expected boundary
	logic [31:0]       tot[12];       // Expected totals
	logic [31:0]       chc[4][12];    // Expected channel counts
	meas_t             m;

	low_cap_indicator_sort #(.NUM_CH(4)) dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .meas_valid_i(meas_valid_i),
		.meas_i(meas_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.handler_o(handler_o), .display_o(display_o), .beep_o(beep_o));
	handler_model hm_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .handler_i(handler_o), .bin_o(bin), .parts_o(parts));

	// Clock
	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end

	// Compare tasks
	task automatic chk_w(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: word %h want %h", $time, g, e);
		end
	endtask
	task automatic chk_b(input logic g, input logic e);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: line %b want %b", $time, g, e);
		end
	endtask
	task automatic chk_d(input disp_t g, input disp_t e);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: display %h want %h", $time, g, e);
		end
	endtask

	// Random value below n
	function automatic int rnd(input int n);
		return ($random(seed) & 32'h7FFFFFFF) % n;
	endfunction

	// Expected low-capacitance decision
	function automatic logic exp_low(input meas_t x);
		logic [79:0] fs;
		logic [2:0]  r;
		r = !ctrl[CTRL_AUTO] ? x.range_code : x.freq == FREQ_120HZ ? RANGE_MIN_120HZ :
			x.freq == FREQ_1KHZ ? RANGE_MIN_1KHZ : RANGE_MIN_1MHZ;
		fs = 80'hF4240;
		repeat (r) fs = fs * 80'h0A;
		return ctrl[CTRL_LOW_CAP_INDICATOR_EN] && !x.overload && 80'(x.parallel_capacitance) * 80'h186A0 <= 80'(pct) * fs;
	endfunction

	// Register write, one strobe cycle
	task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge mclk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	// Register read and compare
	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		chk_w(rdata_o, e);
	endtask
	// One measurement pulse
	task automatic send(input meas_t x);
		@(posedge mclk_i);
		meas_i       <= x;
		meas_valid_i <= 1'b1;
		@(posedge mclk_i);
		meas_valid_i <= 1'b0;
		#1;
	endtask

	// Measurement with comparator on and full expectation
	task automatic run_meas(input meas_t x);
		logic       lc, bp;
		logic [3:0] rc;
		logic [15:0] p;
		lc = exp_low(x);
		rc = x.overload ? CNT_OVERRANGE_FLAG : x.cls;
		bp = ctrl[6:5] == BEEP_FAIL ? (x.overload || lc || x.cls == CLS_REJECT || x.cls == CLS_AUX) :
			ctrl[6:5] == BEEP_PASS && !x.overload && !lc && x.cls inside {[4'h1:4'h9]};
		if (ctrl[CTRL_CNT_EN]) begin
			tot[rc] = tot[rc] + 1;
			if (ctrl[CTRL_MULTI]) chc[x.chan][rc] = chc[x.chan][rc] + 1;
		end
		send(x);
		p = parts;
		chk_b(handler_o.low_cap_or_open_n, !lc);
		chk_b(handler_o.reject_all_result_n, x.overload || x.cls != CLS_REJECT);
		chk_b(handler_o.aux_n, x.overload || x.cls != CLS_AUX);
		chk_b(handler_o.measure_done_n, 1'b0);
		chk_b(handler_o.overrange_flag_n, !x.overload);
		chk_d(display_o, x.overload ? DISP_DASH : lc ? DISP_LOW_CAP_INDICATOR : DISP_CLASS);
		chk_b(beep_o, bp);
		@(posedge mclk_i);
		#1;
		chk_w({28'h0, bin}, (x.overload || x.cls == 4'h0 || x.cls > 4'h9) ? 32'h0 : {28'h0, x.cls});
		chk_w({16'h0, parts}, {16'h0, p + 16'h0001});
		chk_b(handler_o.measure_done_n, 1'b1);
		rchk(REG_RESULT, {16'h0, 3'h0, x.chan, x.overload ? STAT_OVERRANGE_FLAG : lc ? STAT_LOW_CAP_INDICATOR : STAT_OK, 3'h0, lc,
			x.overload ? CLS_NONE : x.cls});
	endtask

	// Read all counters against expectation
	task automatic cmp_counts;
		for (int k = 0; k < 12; k++) begin
			rchk(REG_TOTAL + 12'(4 * k), tot[k]);
			for (int c = 0; c < 4; c++) rchk(REG_CHAN + 12'(64 * c + 4 * k), chc[c][k]);
		end
	endtask

	task automatic end_test(input string s);
		$display("test %0s done", s);
	endtask

	// Verdict
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (40000) @(posedge mclk_i);
		n_errors++;
		$display("unexpected at %0t: run too long", $time);
		final_report;
	end

	// Main sequence
	initial begin
		{rst_n_i, meas_valid_i, wr_i, rd_i, addr_i, wdata_i, meas_i} = '0;
		ce_i = 1'b1;
		ctrl = CTRL_RST;
		pct  = PCT_RST;
		for (int k = 0; k < 12; k++) begin
			tot[k] = '0;
			for (int c = 0; c < 4; c++) chc[c][k] = '0;
		end
		repeat (5) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		rchk(REG_CTRL, 32'h00000040);
		rchk(REG_PCT, 32'h00000000);
		rchk(12'h800, 32'h00000000);
		end_test("reset");
		m       = '0;
		m.cls   = 4'h3;
		m.error = 1'b1;
		send(m);
		chk_b(&handler_o.sort_class_n, 1'b1);
		chk_b(handler_o.alarm_n, 1'b0);
		rchk(REG_TOTAL + 12'h00C, 32'h00000000);
		end_test("comparator off");
		wreg(REG_PCT, 32'h000003E8);
		wreg(REG_CMD, 32'h00000001);
		wreg(REG_CMD, 32'h00000001);
		wreg(REG_CMD, 32'h00000002);
		wreg(REG_CMD, 32'h00000003);
		rchk(REG_PCT, 32'h000003E9);
		wreg(REG_PCT, 32'h000003E8);
		pct = 17'h003E8;
		end_test("percentage");
		for (int i = 0; i < 3; i++) begin
			m = '0;
			m.cls = 4'h4;
			m.freq = FREQ_1KHZ;
			m.range_code = (i == 2) ? 3'h4 : 3'h0;
			// Third part: low for its fixed range, just above the auto boundary
			m.parallel_capacitance = (i == 0) ? 48'h2710 : (i == 1) ? 48'h2711 : 48'hF4241;
			ctrl = (i == 2) ? 7'h1F : 7'h0F;
			wreg(REG_CTRL, {25'h0, ctrl});
			run_meas(m);
		end
		end_test("boundary");
		// Clock enable low: a result must leave every output alone
		@(posedge mclk_i);
		ce_i      <= 1'b0;
		m.overload = 1'b1;
		send(m);
		chk_b(handler_o.overrange_flag_n, 1'b1);
		chk_d(display_o, DISP_CLASS);
		chk_b(beep_o, 1'b0);
		@(posedge mclk_i);
		ce_i <= 1'b1;
		end_test("clock enable");
		for (int i = 0; i < 72; i++) begin
			if (i % 8 == 0) begin
				ctrl = {2'(i / 8 % 3), 4'(rnd(16)), 1'b1};
				wreg(REG_CTRL, {25'h0, ctrl});
			end
			m = '0;
			m.parallel_capacitance = 48'(rnd(32'h7FFFFFFF)) >> rnd(28);
			m.range_code = 3'(rnd(5));
			m.freq = freq_t'(2'(rnd(3)));
			m.cls = 4'(rnd(11));
			m.overload = rnd(8) == 0;
			m.chan = 3'(rnd(4));
			run_meas(m);
		end
		end_test("random");
		cmp_counts;
		end_test("counts");
		wreg(REG_CMD, 32'h00000004);
		for (int k = 0; k < 12; k++) begin
			tot[k] = '0;
			for (int c = 0; c < 4; c++) chc[c][k] = '0;
		end
		cmp_counts;
		end_test("clear");
		final_report;
	end
endmodule
